// ===== design/fsc_stats_map.vh
// Purpose: register offsets, field positions and reset values of the frame-size statistics block
// Assumes: 32-bit AXI4-Lite data, byte addresses, one aligned word per register
// Notes:   each counter is 36 bits; low word first, high nibble at the next word
`ifndef FSC_STATS_MAP_VH
`define FSC_STATS_MAP_VH

`define FSC_RX_BASE           16'h3070
`define FSC_TX_BASE           16'h7070
`define FSC_REL_ALL           16'h0000
`define FSC_REL_UNDER         16'h0008
`define FSC_REL_OVER          16'h0010
`define FSC_REL_LEN64         16'h0018
`define FSC_REL_LEN65_127     16'h0020
`define FSC_HI_STEP           16'h0004
`define FSC_REGION_SPAN       16'h0028
`define FSC_CNT_W             36
`define FSC_LO_MSB            31
`define FSC_HI_MSB            35
`define FSC_HI_LSB            32
`define FSC_CNT_RESET         36'h0_0000_0000
`define FSC_LEN_W             16
`define FSC_MIN_LEN           16'h0040
`define FSC_BIN65_LO          16'h0041
`define FSC_BIN65_HI          16'h007f
`define FSC_MAXLEN_RESET      16'h05ee
`define FSC_CFG_RX_MAXLEN     16'h3000
`define FSC_CFG_TX_MAXLEN     16'h7000
`define FSC_RESP_OKAY         2'b00
`define FSC_RESP_SLVERR       2'b10
`define FSC_RX_ALL_LO         16'h3070
`define FSC_RX_ALL_HI         16'h3074
`define FSC_RX_UNDER_LO       16'h3078
`define FSC_RX_UNDER_HI       16'h307c
`define FSC_RX_OVER_LO        16'h3080
`define FSC_RX_OVER_HI        16'h3084
`define FSC_RX_LEN64_LO       16'h3088
`define FSC_RX_LEN64_HI       16'h308c
`define FSC_RX_LEN65_LO       16'h3090
`define FSC_RX_LEN65_HI       16'h3094
`define FSC_TX_ALL_LO         16'h7070
`define FSC_TX_ALL_HI         16'h7074
`define FSC_TX_UNDER_LO       16'h7078
`define FSC_TX_UNDER_HI       16'h707c
`define FSC_TX_OVER_LO        16'h7080
`define FSC_TX_OVER_HI        16'h7084
`define FSC_TX_LEN64_LO       16'h7088
`define FSC_TX_LEN64_HI       16'h708c
`define FSC_TX_LEN65_LO       16'h7090
`define FSC_TX_LEN65_HI       16'h7094

`endif

// ===== design/fsc_stats.v
// Purpose: 36-bit receive and transmit frame-size statistics counters with an AXI4-Lite slave
// Assumes: frame-done strobes come from datapath logic on aclk; length includes the CRC field
// Notes:   counter words are read-only; the two max-length settings are read/write
// How it works
// RL1: one all-frames counter per direction counts every completed frame.
// RL2: per direction, count frames shorter than 64 bytes including CRC.
// RL3: receive oversize counts frames longer than the receive max-length setting.
// RL4: transmit oversize counts frames longer than the transmit max-length setting.
// RL5: per direction, count frames exactly 64 bytes long, any status.
// RL6: per direction, count frames 65 to 127 bytes long, any status.
// RL7: counters are 36 bits; low 32 at first word, top 4 next word.
// RL8: receive counters from 0x3070, transmit counters at same place from 0x7070.
// RL9: receive oversize words at 0x3080 and 0x3084, not shared with transmit.
// RL10: counter words read-only, writes ignored, all counters zero after reset.
// RL11: each counter steps by one per frame at completion and wraps to zero.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "fsc_stats_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fsc_stats (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_frame_done,
  input  wire [15:0] rx_frame_len,
  input  wire        tx_frame_done,
  input  wire [15:0] tx_frame_len
);

  // counter index: 0 all, 1 undersize, 2 oversize, 3 len64, 4 len65_127
  reg  [35:0] rx_cnt [0:4];
  reg  [35:0] tx_cnt [0:4];
  reg  [15:0] rx_maxlen;
  reg  [15:0] tx_maxlen;
  wire [4:0]  rx_hit;
  wire [4:0]  tx_hit;

  // classify one completed frame into its bins
  function [4:0] fsc_classify;
    input [15:0] len;
    input [15:0] maxlen;
    begin
      fsc_classify[0] = 1'b1;                                            // RL1
      fsc_classify[1] = (len < `FSC_MIN_LEN);                            // RL2
      fsc_classify[2] = (len > maxlen);
      fsc_classify[3] = (len == `FSC_MIN_LEN);                           // RL5
      fsc_classify[4] = (len >= `FSC_BIN65_LO) && (len <= `FSC_BIN65_HI); // RL6
    end
  endfunction

  assign rx_hit = fsc_classify(rx_frame_len, rx_maxlen); // RL3
  assign tx_hit = fsc_classify(tx_frame_len, tx_maxlen); // RL4

  // per-counter qualify strobes: a frame lands in every bin it matches in one cycle
  wire        rx_all_hit;
  wire        rx_under_hit;
  wire        rx_over_hit;
  wire        rx_len64_hit;
  wire        rx_len65_hit;
  wire        tx_all_hit;
  wire        tx_under_hit;
  wire        tx_over_hit;
  wire        tx_len64_hit;
  wire        tx_len65_hit;

  assign rx_all_hit   = rx_frame_done && rx_hit[0]; // RL1
  assign rx_under_hit = rx_frame_done && rx_hit[1]; // RL2
  assign rx_over_hit  = rx_frame_done && rx_hit[2]; // RL3
  assign rx_len64_hit = rx_frame_done && rx_hit[3]; // RL5
  assign rx_len65_hit = rx_frame_done && rx_hit[4]; // RL6
  assign tx_all_hit   = tx_frame_done && tx_hit[0]; // RL1
  assign tx_under_hit = tx_frame_done && tx_hit[1]; // RL2
  assign tx_over_hit  = tx_frame_done && tx_hit[2]; // RL4
  assign tx_len64_hit = tx_frame_done && tx_hit[3]; // RL5
  assign tx_len65_hit = tx_frame_done && tx_hit[4]; // RL6

  // one step of a 36-bit counter; the add drops its carry, so all-ones wraps to zero
  function [35:0] fsc_bump;
    input [35:0] cnt;
    input        hit;
    begin
      if (hit)
        fsc_bump = cnt + 36'h1; // RL11
      else
        fsc_bump = cnt;
    end
  endfunction

  reg  [35:0] next_rx_all;
  reg  [35:0] next_rx_under;
  reg  [35:0] next_rx_over;
  reg  [35:0] next_rx_len64;
  reg  [35:0] next_rx_len65;
  reg  [35:0] next_tx_all;
  reg  [35:0] next_tx_under;
  reg  [35:0] next_tx_over;
  reg  [35:0] next_tx_len64;
  reg  [35:0] next_tx_len65;

  always @* begin
    next_rx_all   = fsc_bump(rx_cnt[0], rx_all_hit);
    next_rx_under = fsc_bump(rx_cnt[1], rx_under_hit);
    next_rx_over  = fsc_bump(rx_cnt[2], rx_over_hit);
    next_rx_len64 = fsc_bump(rx_cnt[3], rx_len64_hit);
    next_rx_len65 = fsc_bump(rx_cnt[4], rx_len65_hit);
    next_tx_all   = fsc_bump(tx_cnt[0], tx_all_hit);
    next_tx_under = fsc_bump(tx_cnt[1], tx_under_hit);
    next_tx_over  = fsc_bump(tx_cnt[2], tx_over_hit);
    next_tx_len64 = fsc_bump(tx_cnt[3], tx_len64_hit);
    next_tx_len65 = fsc_bump(tx_cnt[4], tx_len65_hit);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt[0] <= `FSC_CNT_RESET; // RL10
      rx_cnt[1] <= `FSC_CNT_RESET;
      rx_cnt[2] <= `FSC_CNT_RESET;
      rx_cnt[3] <= `FSC_CNT_RESET;
      rx_cnt[4] <= `FSC_CNT_RESET;
      tx_cnt[0] <= `FSC_CNT_RESET;
      tx_cnt[1] <= `FSC_CNT_RESET;
      tx_cnt[2] <= `FSC_CNT_RESET;
      tx_cnt[3] <= `FSC_CNT_RESET;
      tx_cnt[4] <= `FSC_CNT_RESET;
    end else begin
      rx_cnt[0] <= next_rx_all;
      rx_cnt[1] <= next_rx_under;
      rx_cnt[2] <= next_rx_over;
      rx_cnt[3] <= next_rx_len64;
      rx_cnt[4] <= next_rx_len65;
      tx_cnt[0] <= next_tx_all;
      tx_cnt[1] <= next_tx_under;
      tx_cnt[2] <= next_tx_over;
      tx_cnt[3] <= next_tx_len64;
      tx_cnt[4] <= next_tx_len65;
    end
  end

  // map an address to a word: bit5 = valid, bit4 = tx, [3:1] = counter, [0] = hi word
  // a flat table costs a few gates more than base arithmetic but keeps every
  // mapped word visible; unaligned addresses fall out as unmapped
  function [5:0] fsc_decode;
    input [15:0] addr;
    begin
      case (addr)
        `FSC_RX_ALL_LO:   fsc_decode = 6'b100000; // RL8
        `FSC_RX_ALL_HI:   fsc_decode = 6'b100001;
        `FSC_RX_UNDER_LO: fsc_decode = 6'b100010;
        `FSC_RX_UNDER_HI: fsc_decode = 6'b100011;
        `FSC_RX_OVER_LO:  fsc_decode = 6'b100100; // RL9
        `FSC_RX_OVER_HI:  fsc_decode = 6'b100101; // RL9
        `FSC_RX_LEN64_LO: fsc_decode = 6'b100110;
        `FSC_RX_LEN64_HI: fsc_decode = 6'b100111;
        `FSC_RX_LEN65_LO: fsc_decode = 6'b101000;
        `FSC_RX_LEN65_HI: fsc_decode = 6'b101001;
        `FSC_TX_ALL_LO:   fsc_decode = 6'b110000; // RL8
        `FSC_TX_ALL_HI:   fsc_decode = 6'b110001;
        `FSC_TX_UNDER_LO: fsc_decode = 6'b110010;
        `FSC_TX_UNDER_HI: fsc_decode = 6'b110011;
        `FSC_TX_OVER_LO:  fsc_decode = 6'b110100;
        `FSC_TX_OVER_HI:  fsc_decode = 6'b110101;
        `FSC_TX_LEN64_LO: fsc_decode = 6'b110110;
        `FSC_TX_LEN64_HI: fsc_decode = 6'b110111;
        `FSC_TX_LEN65_LO: fsc_decode = 6'b111000;
        `FSC_TX_LEN65_HI: fsc_decode = 6'b111001;
        default:          fsc_decode = 6'b000000;
      endcase
    end
  endfunction

  // write channel: both halves taken together; only the max-length settings accept data
  wire        wr_go;
  wire [5:0]  wr_dec;
  wire        wr_cfg;
  wire        wr_rx_cfg;
  wire        wr_tx_cfg;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_go     = s_axi_awready;
  assign wr_dec    = fsc_decode(s_axi_awaddr);
  assign wr_rx_cfg = (s_axi_awaddr == `FSC_CFG_RX_MAXLEN);
  assign wr_tx_cfg = (s_axi_awaddr == `FSC_CFG_TX_MAXLEN);
  assign wr_cfg    = wr_rx_cfg || wr_tx_cfg;

  // byte-lane merge shared by both settings; lanes above bit 15 have no storage
  function [15:0] fsc_merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      fsc_merge = old;
      if (strb[0])
        fsc_merge[7:0] = data[7:0];
      if (strb[1])
        fsc_merge[15:8] = data[15:8];
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FSC_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // counter words accept and drop the write; unmapped gets an error
        s_axi_bresp  <= (wr_cfg || wr_dec[5]) ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR; // RL10
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_maxlen <= `FSC_MAXLEN_RESET;
    end else if (wr_go && wr_rx_cfg) begin
      rx_maxlen <= fsc_merge(rx_maxlen, s_axi_wdata, s_axi_wstrb);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_maxlen <= `FSC_MAXLEN_RESET;
    end else if (wr_go && wr_tx_cfg) begin
      tx_maxlen <= fsc_merge(tx_maxlen, s_axi_wdata, s_axi_wstrb);
    end
  end

  // read channel: the word is chosen combinationally and loaded only when a read is taken
  reg  [31:0] next_rdata;
  reg  [1:0]  next_rresp;
  assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `FSC_RESP_OKAY;
    case (s_axi_araddr)
      `FSC_RX_ALL_LO: begin
        next_rdata = rx_cnt[0][`FSC_LO_MSB:0]; // RL7
      end
      `FSC_RX_ALL_HI: begin
        next_rdata = {28'h000_0000, rx_cnt[0][`FSC_HI_MSB:`FSC_HI_LSB]}; // RL7
      end
      `FSC_RX_UNDER_LO: begin
        next_rdata = rx_cnt[1][`FSC_LO_MSB:0];
      end
      `FSC_RX_UNDER_HI: begin
        next_rdata = {28'h000_0000, rx_cnt[1][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_RX_OVER_LO: begin
        next_rdata = rx_cnt[2][`FSC_LO_MSB:0]; // RL9
      end
      `FSC_RX_OVER_HI: begin
        next_rdata = {28'h000_0000, rx_cnt[2][`FSC_HI_MSB:`FSC_HI_LSB]}; // RL9
      end
      `FSC_RX_LEN64_LO: begin
        next_rdata = rx_cnt[3][`FSC_LO_MSB:0];
      end
      `FSC_RX_LEN64_HI: begin
        next_rdata = {28'h000_0000, rx_cnt[3][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_RX_LEN65_LO: begin
        next_rdata = rx_cnt[4][`FSC_LO_MSB:0];
      end
      `FSC_RX_LEN65_HI: begin
        next_rdata = {28'h000_0000, rx_cnt[4][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_TX_ALL_LO: begin
        next_rdata = tx_cnt[0][`FSC_LO_MSB:0]; // RL8
      end
      `FSC_TX_ALL_HI: begin
        next_rdata = {28'h000_0000, tx_cnt[0][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_TX_UNDER_LO: begin
        next_rdata = tx_cnt[1][`FSC_LO_MSB:0];
      end
      `FSC_TX_UNDER_HI: begin
        next_rdata = {28'h000_0000, tx_cnt[1][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_TX_OVER_LO: begin
        next_rdata = tx_cnt[2][`FSC_LO_MSB:0];
      end
      `FSC_TX_OVER_HI: begin
        next_rdata = {28'h000_0000, tx_cnt[2][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_TX_LEN64_LO: begin
        next_rdata = tx_cnt[3][`FSC_LO_MSB:0];
      end
      `FSC_TX_LEN64_HI: begin
        next_rdata = {28'h000_0000, tx_cnt[3][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_TX_LEN65_LO: begin
        next_rdata = tx_cnt[4][`FSC_LO_MSB:0];
      end
      `FSC_TX_LEN65_HI: begin
        next_rdata = {28'h000_0000, tx_cnt[4][`FSC_HI_MSB:`FSC_HI_LSB]};
      end
      `FSC_CFG_RX_MAXLEN: begin
        next_rdata = {16'h0000, rx_maxlen};
      end
      `FSC_CFG_TX_MAXLEN: begin
        next_rdata = {16'h0000, tx_maxlen};
      end
      default: begin
        // unmapped or unaligned: error with zero data
        next_rresp = `FSC_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FSC_RESP_OKAY;
    end else begin
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // fsc_stats

`default_nettype wire

// ===== bench/fsc_stats_checker.sv
// Purpose: bus handshake checks for fsc_stats
// Assumes: one aclk domain, aresetn synchronous
// Notes: bound to every fsc_stats instance
`timescale 1ns/1ps
`default_nettype none
module fsc_stats_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wready;
  endsequence
  rd_answer_a: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_close_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  wr_answer_a: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_close_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  aw_pair_a: assert property (s_axi_awready |-> s_axi_wvalid && s_axi_awvalid && !s_axi_bvalid)
    else $error("write half taken");
endmodule // fsc_stats_checker
bind fsc_stats fsc_stats_checker i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== bench/tb_fsc_stats.sv
// Purpose: self-checking bench for fsc_stats
// Assumes: AXI4-Lite master tasks, frame strobes driven on back-to-back cycles in short bursts
// Notes: 36-bit wrap is out of reach in a short run
`timescale 1ns/1ps
`default_nettype none
module tb_fsc_stats;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, rx_done = 0, tx_done = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = 0, araddr = 0, rx_len = 0, tx_len = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          err_count = 0, checks = 0, cyc = 0;
  fsc_stats i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_frame_done(rx_done), .rx_frame_len(rx_len), .tx_frame_done(tx_done),
    .tx_frame_len(tx_len));
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      stop_test();
    end
  end
  task chk(input logic [35:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // ready is raised a cycle late so the slave has to hold its answer
  task rd(input logic [15:0] a);
    araddr <= a;
    arvalid <= 1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 0;
    @(posedge aclk);
    rready <= 1;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  task wr(input logic [15:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 0;
    wvalid <= 0;
    @(posedge aclk);
    bready <= 1;
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    r = bresp;
    bready <= 0;
  endtask
  task cnt(input logic [15:0] a, input logic [35:0] e);
    logic [31:0] lo;
    rd(a);
    lo = d;
    rd(a + 16'h4);
    chk({d[3:0], lo}, e);
    chk(d[31:4], 0);
  endtask
  task t_reset();
    for (int i = 0; i < 10; i++) cnt((i < 5 ? 16'h3070 : 16'h7070) + 16'(8 * (i % 5)), 0);
  endtask
  task t_bins();
    logic [15:0] lens [7] = '{63, 64, 65, 127, 128, 1518, 1519};
    for (int i = 0; i < 7; i++) begin
      rx_done <= 1;
      tx_done <= 1;
      rx_len <= lens[i];
      tx_len <= lens[6 - i];
      @(posedge aclk);
    end
    rx_done <= 0;
    tx_done <= 0;
    @(posedge aclk);
    for (int k = 0; k < 2; k++) begin
      cnt(k ? 16'h7070 : 16'h3070, 7);
      cnt(k ? 16'h7078 : 16'h3078, 1);
      cnt(k ? 16'h7080 : 16'h3080, 1);
      cnt(k ? 16'h7088 : 16'h3088, 1);
      cnt(k ? 16'h7090 : 16'h3090, 2);
    end
  endtask
  task t_ro();
    wr(16'h3070, 32'hffff_ffff);
    chk(r, 2'b00);
    cnt(16'h3070, 7);
    rd(16'h3098);
    chk({r, d}, 0 | 34'h2_0000_0000);
  endtask
  task t_max();
    wr(16'h7000, 32'd100);
    for (int i = 0; i < 2; i++) begin
      tx_done <= 1;
      rx_done <= 1;
      tx_len <= 16'(100 + i);
      rx_len <= 16'd101;
      @(posedge aclk);
    end
    tx_done <= 0;
    rx_done <= 0;
    @(posedge aclk);
    cnt(16'h7080, 2);
    cnt(16'h3080, 1);
    cnt(16'h7090, 4);
  endtask
  task stop_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_bins();
    t_ro();
    t_max();
    stop_test();
  end
endmodule // tb_fsc_stats
`default_nettype wire
